/* vectored_interrupt_controller_test.sv */
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ns
`default_nettype none
module vectored_interrupt_controller_test
  import vic_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_pin0, ext_pin1, software_break;
  logic core_ack, core_reti, irq, took;
  logic [7:0] paddr, pat;
  logic [31:0] pwdata, prdata;
  logic [15:0] took_vec;
  logic [9:0] pr;
  logic [3:0] dly;
  vic_periph_s periph;
  vic_core_req_s core_req;
  int failures, num_checks, nret, ntk, j;
  logic [15:0] tq[$];
  int pend[$];
  logic [31:0] rst_v [8] = '{32'h0, 32'h3FF, 32'h3FF, 32'h2A, 32'h0, 32'h0, 32'h0, 32'h0};
  vic_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_pin0, .ext_pin1, .periph, .software_break, .core_req, .core_ack, .core_reti, .irq);
  vic_core_model core (.pclk, .presetn, .core_req, .dly, .core_ack, .core_reti, .took, .took_vec);
  // free-running clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // monitor collects taken vectors, so a fast core is never missed
  always @(posedge pclk) begin
    if (took === 1'b1) tq.push_back(took_vec);
    if (core_reti === 1'b1) nret++;
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic lost();
    failures++;
    complete_run();
  endtask : lost
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, want, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) lost();
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] want, input logic werr);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    check("rdata", r, want);
    check("pslverr", {31'h0, er}, {31'h0, werr});
  endtask : rchk
  function automatic int bitidx(input int i);
    return (i == 0) ? 7 : 9 - i;
  endfunction : bitidx
  function automatic logic [15:0] vec_of(input int i);
    return 16'h0004 + 16'(2 * i);
  endfunction : vec_of
  task automatic pulse(input logic [7:0] p, input logic b);
    @(posedge pclk);
    periph <= vic_periph_s'(p);
    software_break <= b;
    @(posedge pclk);
    periph <= '0;
    software_break <= 1'b0;
  endtask : pulse
  // pins go through a synchroniser, so they are held for several cycles
  task automatic raise(input int i);
    if (i == 1) ext_pin0 <= 1'b1;
    else if (i == 2) ext_pin1 <= 1'b1;
    pulse((i == 1 || i == 2) ? 8'h00 : 8'(1 << bitidx(i)), 1'b0);
    repeat (3) @(posedge pclk);
    ext_pin0 <= 1'b0;
    ext_pin1 <= 1'b0;
  endtask : raise
  task automatic take(input logic [15:0] want);
    int n;
    n = 0;
    while (tq.size() == 0 && n < 80) begin
      @(posedge pclk);
      n++;
    end
    if (tq.size() == 0) lost();
    check("vector", {16'h0, tq.pop_front()}, {16'h0, want});
    ntk++;
    n = 0;
    while (nret < ntk && n < 80) begin
      @(posedge pclk);
      n++;
    end
    if (nret < ntk) lost();
  endtask : take
  initial begin
    {presetn, psel, penable, pwrite, ext_pin0, ext_pin1, software_break} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    periph = '0;
    dly = 4'h0;
    void'($urandom(32'h28DDC4A8));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 8; k++) rchk(8'(4 * k), rst_v[k], k == 7);
    wr(OFS_VEC, 32'hFFFF);
    rchk(OFS_VEC, 32'h0, 1'b0);
    check("irq", {31'h0, irq}, 32'h0);
    check("pready", {31'h0, pready}, 32'h1);
    $display("test reset done");
    wr(OFS_MASK, 32'h0);
    wr(OFS_CTRL, 32'h2F);
    for (int i = 0; i < NSRC; i++) begin
      dly = 4'($urandom_range(0, 5));
      raise(i);
      take(vec_of(i));
    end
    rchk(OFS_VEC, 32'h16, 1'b0);
    rchk(OFS_REQ, 32'h0, 1'b0);
    $display("test sources done");
    // model: pick the lowest index among the high group, else among all
    for (int t = 0; t < 6; t++) begin
      pat = 8'($urandom) | 8'h01;
      pr = 10'($urandom);
      wr(OFS_PRIO, {22'h0, pr});
      pulse(pat, 1'b0);
      pend.delete();
      for (int i = 0; i < NSRC; i++) if (i != 1 && i != 2 && pat[bitidx(i)]) pend.push_back(i);
      while (pend.size() > 0) begin
        j = 0;
        foreach (pend[k]) if (!pr[pend[k]] && pr[pend[j]]) j = k;
        take(vec_of(pend[j]));
        pend.delete(j);
      end
    end
    $display("test priority done");
    wr(OFS_MASK, 32'h3FF);
    wr(OFS_IMASK, 32'h20);
    pulse(8'h10, 1'b0);
    repeat (3) @(posedge pclk);
    check("valid", {31'h0, core_req.valid}, 32'h0);
    check("irq", {31'h0, irq}, 32'h1);
    rchk(OFS_REQ, 32'h20, 1'b0);
    wr(OFS_ISTAT, 32'hFFF);
    wr(OFS_REQ, 32'h20);
    rchk(OFS_REQ, 32'h0, 1'b0);
    check("irq", {31'h0, irq}, 32'h0);
    $display("test mask done");
    wr(OFS_CTRL, 32'h2A);
    pulse(8'h80, 1'b0);
    take(16'h0004);
    pulse(8'h00, 1'b1);
    take(16'h003E);
    rchk(OFS_ISTAT, 32'hC00, 1'b0);
    $display("test non-maskable done");
    complete_run();
  end
endmodule : vectored_interrupt_controller_test
`default_nettype wire

/* vic_core_model.sv */
// processor core stand-in: takes each request after a delay, returns from service later
`timescale 1ns/1ns
`default_nettype none
module vic_core_model
  import vic_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire vic_core_req_s core_req, // request from controller
  input wire logic [3:0] dly, // cycles before taking
  output logic core_ack, // take pulse
  output logic core_reti, // return pulse
  output logic took, // strobe with the taken vector
  output logic [15:0] took_vec // taken vector
);
  int wcnt;
  int rcnt;
  // a slow core leaves valid standing; never acks on two edges running
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt = 0;
      rcnt = 0;
      core_ack <= 1'b0;
      core_reti <= 1'b0;
      took <= 1'b0;
      took_vec <= 16'h0000;
    end else begin
      core_ack <= 1'b0;
      core_reti <= 1'b0;
      took <= 1'b0;
      if (rcnt > 0) begin
        rcnt = rcnt - 1;
        core_reti <= (rcnt == 0);
      end
      if (core_req.valid && !core_ack) begin
        if (wcnt >= dly) begin
          core_ack <= 1'b1;
          took <= 1'b1;
          took_vec <= core_req.vector;
          wcnt = 0;
          rcnt = dly + 2;
        end else wcnt = wcnt + 1;
      end
    end
  end
endmodule : vic_core_model
`default_nettype wire

/* vic_ctrl.sv */
// module: vectored interrupt controller with apb register file and core request port
//
// Overview of operation
// R1 - twelve sources: one non-maskable, ten maskable, one software break.
// R2 - watchdog overflow in watchdog mode raises non-maskable request, vector 0004H.
// R3 - watchdog overflow in interval mode raises maskable request, default priority 0.
// R4 - pin 0 edge requests priority 1 vector 0006H; pin 1 priority 2 0008H.
// R5 - remote timer edges request priorities 3 and 4, vectors 000AH and 000CH.
// R6 - key-scan timing requests priority 5, vector 000EH.
// R7 - serial transfer end requests priority 6, vector 0010H.
// R8 - first pwm timer match requests priority 7, vector 0012H.
// R9 - second pwm match priority 8 vector 0014H; conversion end priority 9 0016H.
// R10 - simultaneous maskable requests served by default priority, 0 highest, 9 lowest.
// R11 - per-source request, mask, priority flags; global enable and in-service flag gate.
// R12 - software break raises non-maskable request through break vector, ignoring masks.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module vic_ctrl
  import vic_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic ext_pin0, // external interrupt pin 0, asynchronous
  input wire logic ext_pin1, // external interrupt pin 1, asynchronous
  input wire vic_periph_s periph, // peripheral event pulses
  input wire logic software_break, // core executed the break instruction
  output vic_core_req_s core_req, // request to core
  input wire logic core_ack, // core takes the request
  input wire logic core_reti, // core returns from service
  output logic irq // level interrupt from status and mask
);

  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_d_r;
  logic [NSRC-1:0] req_r;
  logic [NSRC-1:0] req_nxt;
  logic [NSRC-1:0] mask_flag_r;
  logic [NSRC-1:0] mask_flag_nxt;
  logic [NSRC-1:0] priority_select_flag_r;
  logic [NSRC-1:0] priority_select_flag_nxt;
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [NEV-1:0] istat_r;
  logic [NEV-1:0] istat_nxt;
  logic [NEV-1:0] imask_r;
  logic [NEV-1:0] imask_nxt;
  logic nmi_pend_r;
  logic nmi_pend_nxt;
  logic brk_pend_r;
  logic brk_pend_nxt;
  vic_core_req_s req_out_r;
  vic_core_req_s req_out_nxt;
  vic_kind_e kind_r;
  vic_kind_e kind_nxt;
  logic [3:0] idx_r;
  logic [3:0] idx_nxt;
  logic [15:0] last_vec_r;
  logic [15:0] last_vec_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] pin_edge;
  logic [NSRC-1:0] src_ev;
  logic nmi_ev;
  logic [NSRC-1:0] eligible;
  logic enc_found;
  logic [3:0] enc_idx;
  logic wr_acc;
  logic rd_setup;
  logic taken;
  logic global_irq_enable;
  logic in_service_priority;
  logic wdt_interval;

  // maps a source index to its vector, two bytes per table entry
  function automatic logic [15:0] vector_of(input logic [3:0] i);
    return VEC_MASK_BASE + {11'h000, i, 1'b0};
  endfunction : vector_of

  // edge selection shared by both external pins
  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic prev);
    logic r;
    r = 1'b0;
    unique case (vic_edge_e'(sel))
      EDGE_NONE: r = 1'b0;
      EDGE_RISE: r = now & ~prev;
      EDGE_FALL: r = ~now & prev;
      EDGE_BOTH: r = now ^ prev;
    endcase
    return r;
  endfunction : edge_hit

  // address decode, used for both read and write
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == OFS_REQ) || (a == OFS_MASK) || (a == OFS_PRIO) || (a == OFS_CTRL) ||
           (a == OFS_VEC) || (a == OFS_ISTAT) || (a == OFS_IMASK);
  endfunction : addr_ok

  assign global_irq_enable = ctrl_r[CTRL_IE];
  assign in_service_priority = ctrl_r[CTRL_ISP];
  assign wdt_interval = ctrl_r[CTRL_WDT_ITV];
  assign wr_acc = psel & penable & pwrite & addr_ok(paddr);
  assign rd_setup = psel & ~penable & ~pwrite;
  assign taken = core_ack & req_out_r.valid;

  // pins pass two flops before the edge detector; third stage keeps the previous level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      pin_d_r <= 2'h0;
    end else begin
      pin_s1_r <= {ext_pin1, ext_pin0};
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  // edge detection for each external pin
  for (genvar p = 0; p < 2; p++) begin : g_pin
    assign pin_edge[p] = edge_hit(ctrl_r[CTRL_EDGE0_LO + 2*p +: 2], pin_s2_r[p], pin_d_r[p]);
  end

  // collect source events in default-priority order
  always_comb begin
    src_ev = '0;
    src_ev[SRC_WDT] = periph.watchdog_overflow_irq & wdt_interval; // see R3
    src_ev[SRC_PIN0] = pin_edge[0]; // see R4
    src_ev[SRC_PIN1] = pin_edge[1]; // see R4
    src_ev[SRC_TM_EDGE0] = periph.remote_timer_edge0_irq; // see R5
    src_ev[SRC_TM_EDGE1] = periph.remote_timer_edge1_irq; // see R5
    src_ev[SRC_KEY] = periph.key_scan_irq; // see R6
    src_ev[SRC_SERIAL] = periph.serial_done_irq; // see R7
    src_ev[SRC_PWM0] = periph.pwm_timer0_match_irq; // see R8
    src_ev[SRC_PWM1] = periph.pwm_timer1_match_irq; // see R9
    src_ev[SRC_CONV] = periph.conversion_done_irq; // see R9
    nmi_ev = periph.watchdog_overflow_irq & ~wdt_interval; // see R2
  end

  // mask, priority, global enable and in-service flag gate acceptance
  assign eligible = req_r & ~mask_flag_r & {NSRC{global_irq_enable}} &
                    (~priority_select_flag_r | {NSRC{in_service_priority}}); // see R11

  vic_prio_enc u_enc (
    .eligible(eligible),
    .prio_low(priority_select_flag_r),
    .found(enc_found),
    .idx(enc_idx)
  );

  // flag next state; event sets are applied last so an event set beats a clear
  always_comb begin
    req_nxt = req_r;
    mask_flag_nxt = mask_flag_r;
    priority_select_flag_nxt = priority_select_flag_r;
    ctrl_nxt = ctrl_r;
    imask_nxt = imask_r;
    istat_nxt = istat_r;
    nmi_pend_nxt = nmi_pend_r;
    brk_pend_nxt = brk_pend_r;
    last_vec_nxt = last_vec_r;
    if (wr_acc) begin
      unique case (paddr)
        OFS_REQ: req_nxt = req_r & ~pwdata[NSRC-1:0];
        OFS_MASK: mask_flag_nxt = pwdata[NSRC-1:0];
        OFS_PRIO: priority_select_flag_nxt = pwdata[NSRC-1:0];
        OFS_CTRL: ctrl_nxt = pwdata[CTRL_W-1:0];
        OFS_ISTAT: istat_nxt = istat_r & ~pwdata[NEV-1:0];
        OFS_IMASK: imask_nxt = pwdata[NEV-1:0];
        default: ;
      endcase
    end
    // return from service reopens acceptance of all levels
    if (core_reti) begin
      ctrl_nxt[CTRL_IE] = 1'b1;
      ctrl_nxt[CTRL_ISP] = 1'b1;
    end
    // taking a request blocks further maskable ones until return
    if (taken) begin
      last_vec_nxt = req_out_r.vector;
      ctrl_nxt[CTRL_IE] = 1'b0;
      unique case (kind_r)
        KIND_NMI: nmi_pend_nxt = 1'b0; // see R2
        KIND_BRK: brk_pend_nxt = 1'b0; // see R12
        KIND_MASK: begin
          req_nxt[idx_r] = 1'b0;
          if (!priority_select_flag_r[idx_r]) begin
            ctrl_nxt[CTRL_ISP] = 1'b0; // see R11
          end
        end
        KIND_NONE: ;
      endcase
    end
    req_nxt = req_nxt | src_ev; // see R1
    nmi_pend_nxt = nmi_pend_nxt | nmi_ev; // see R2
    brk_pend_nxt = brk_pend_nxt | software_break; // see R12
    istat_nxt = istat_nxt | {software_break, nmi_ev, src_ev};
  end

  // non-maskable sources outrank the maskable pick; valid drops for the cycle after a take
  always_comb begin
    kind_nxt = KIND_NONE;
    idx_nxt = enc_idx;
    req_out_nxt.nmi = 1'b0;
    req_out_nxt.vector = vector_of(enc_idx); // see R4
    if (nmi_pend_r) begin
      kind_nxt = KIND_NMI;
      req_out_nxt.nmi = 1'b1;
      req_out_nxt.vector = VEC_NMI; // see R2
    end else if (brk_pend_r) begin
      kind_nxt = KIND_BRK;
      req_out_nxt.nmi = 1'b1;
      req_out_nxt.vector = VEC_BRK; // see R12
    end else if (enc_found) begin
      kind_nxt = KIND_MASK; // see R10
    end
    req_out_nxt.valid = (kind_nxt != KIND_NONE) && !taken;
  end

  // read data is captured in the setup phase so it stands through the access phase
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_setup) begin
      rdata_nxt = 32'h0000_0000;
      unique case (paddr)
        OFS_REQ: rdata_nxt[NSRC-1:0] = req_r;
        OFS_MASK: rdata_nxt[NSRC-1:0] = mask_flag_r;
        OFS_PRIO: rdata_nxt[NSRC-1:0] = priority_select_flag_r;
        OFS_CTRL: rdata_nxt[CTRL_W-1:0] = ctrl_r;
        OFS_VEC: rdata_nxt[15:0] = last_vec_r;
        OFS_ISTAT: rdata_nxt[NEV-1:0] = istat_r;
        OFS_IMASK: rdata_nxt[NEV-1:0] = imask_r;
        default: ;
      endcase
    end
  end

  // all state registers except the pin synchroniser; masks start closed and the enable starts off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r <= '0;
      mask_flag_r <= MASK_RST;
      priority_select_flag_r <= PRIO_RST;
      ctrl_r <= CTRL_RST;
      istat_r <= '0;
      imask_r <= IMASK_RST;
      nmi_pend_r <= 1'b0;
      brk_pend_r <= 1'b0;
      req_out_r <= '0;
      kind_r <= KIND_NONE;
      idx_r <= 4'h0;
      last_vec_r <= 16'h0000;
      rdata_r <= 32'h0000_0000;
    end else begin
      req_r <= req_nxt;
      mask_flag_r <= mask_flag_nxt;
      priority_select_flag_r <= priority_select_flag_nxt;
      ctrl_r <= ctrl_nxt;
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
      nmi_pend_r <= nmi_pend_nxt;
      brk_pend_r <= brk_pend_nxt;
      req_out_r <= req_out_nxt;
      kind_r <= kind_nxt;
      idx_r <= idx_nxt;
      last_vec_r <= last_vec_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // zero-wait slave; unmapped addresses answer with an error and zero data
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok(paddr);
  assign prdata = rdata_r;
  assign core_req = req_out_r;
  assign irq = |(istat_r & imask_r);

endmodule : vic_ctrl
`default_nettype wire

/* vic_ctrl_sva.sv */
// assertion checker watching the interrupt controller ports
`timescale 1ns/1ns
`default_nettype none
module vic_ctrl_sva
  import vic_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic software_break, // break pulse
  input wire vic_core_req_s core_req, // request to core
  input wire logic core_ack, // core takes request
  input wire logic core_reti // core returns
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a taken request followed by a cycle with no return and no bus traffic
  sequence s_taken;
    core_req.valid && core_ack;
  endsequence
  sequence s_quiet;
    !core_reti && !psel;
  endsequence
  a_vec_range: assert property (core_req.valid && !core_req.nmi |->
    core_req.vector inside {[16'h0004:16'h0016]} && !core_req.vector[0]) else $error("maskable vector off table");
  a_nmi_vec: assert property (core_req.valid && core_req.nmi |->
    core_req.vector == 16'h0004 || core_req.vector == 16'h003E) else $error("non-maskable vector wrong");
  a_valid_hold: assert property (core_req.valid && !core_ack |=>
    core_req.valid && $stable(core_req.vector)) else $error("request dropped before take");
  a_ack_drop: assert property (s_taken |=> !core_req.valid) else $error("request stayed after take");
  a_slverr_phase: assert property (pslverr |-> psel && penable) else $error("error outside access");
  a_err_rdata: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  // the pending flag is set at the pulse edge and the registered request follows one edge later
  a_break_req: assert property (software_break && !core_req.valid && !$past(core_req.valid) |-> ##2
    core_req.valid && core_req.nmi) else $error("break not requested");
  // maskable interrupts stay disabled after a take until the core returns
  a_ie_block: assert property (s_taken ##1 s_quiet |=> !(core_req.valid && !core_req.nmi) [*2])
    else $error("maskable request while disabled");
endmodule : vic_ctrl_sva
bind vic_ctrl vic_ctrl_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .software_break, .core_req, .core_ack, .core_reti);
`default_nettype wire

/* vic_pkg.sv */
// package: constants, register map and carrier types of the vectored interrupt controller
package vic_pkg;

  // source count and indices in default-priority order (index 0 is highest)
  localparam int NSRC = 10;
  localparam int SRC_WDT = 0;
  localparam int SRC_PIN0 = 1;
  localparam int SRC_PIN1 = 2;
  localparam int SRC_TM_EDGE0 = 3;
  localparam int SRC_TM_EDGE1 = 4;
  localparam int SRC_KEY = 5;
  localparam int SRC_SERIAL = 6;
  localparam int SRC_PWM0 = 7;
  localparam int SRC_PWM1 = 8;
  localparam int SRC_CONV = 9;

  // apb byte offsets
  localparam logic [7:0] OFS_REQ = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_PRIO = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_VEC = 8'h10;
  localparam logic [7:0] OFS_ISTAT = 8'h14;
  localparam logic [7:0] OFS_IMASK = 8'h18;

  // control register fields
  localparam int CTRL_IE = 0;
  localparam int CTRL_ISP = 1;
  localparam int CTRL_WDT_ITV = 2;
  localparam int CTRL_EDGE0_LO = 3;
  localparam int CTRL_EDGE1_LO = 5;
  localparam int CTRL_W = 7;

  // status event bits beyond the ten sources
  localparam int NEV = 12;
  localparam int EV_NMI = 10;
  localparam int EV_BRK = 11;

  // reset values
  localparam logic [NSRC-1:0] MASK_RST = 10'h3FF;
  localparam logic [NSRC-1:0] PRIO_RST = 10'h3FF;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h2A;
  localparam logic [NEV-1:0] IMASK_RST = 12'h000;

  // vector table
  localparam logic [15:0] VEC_NMI = 16'h0004;
  localparam logic [15:0] VEC_MASK_BASE = 16'h0004;
  localparam logic [15:0] VEC_BRK = 16'h003E;

  typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} vic_edge_e;
  typedef enum logic [1:0] {KIND_NONE, KIND_NMI, KIND_BRK, KIND_MASK} vic_kind_e;

  // one-cycle event pulses from on-chip peripherals
  typedef struct packed {
    logic watchdog_overflow_irq;
    logic remote_timer_edge0_irq;
    logic remote_timer_edge1_irq;
    logic key_scan_irq;
    logic serial_done_irq;
    logic pwm_timer0_match_irq;
    logic pwm_timer1_match_irq;
    logic conversion_done_irq;
  } vic_periph_s;

  // request towards the processor core
  typedef struct packed {
    logic valid;
    logic nmi;
    logic [15:0] vector;
  } vic_core_req_s;

endpackage : vic_pkg

/* vic_prio_enc.sv */
// module: two-level fixed priority pick among eligible maskable requests
`timescale 1ns/1ns
`default_nettype none
module vic_prio_enc
  import vic_pkg::*;
(
  input wire logic [NSRC-1:0] eligible, // gated request flags
  input wire logic [NSRC-1:0] prio_low, // 1 marks a low-priority source
  output logic found, // some request eligible
  output logic [3:0] idx // chosen source index
);

  // lowest set index wins, so index 0 has the highest default priority
  function automatic logic [4:0] first_set(input logic [NSRC-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : first_set

  logic [4:0] hi_pick;
  logic [4:0] lo_pick;

  // high group is served before low group, default order inside each
  always_comb begin
    hi_pick = first_set(eligible & ~prio_low); // see R10
    lo_pick = first_set(eligible & prio_low); // see R10
    found = hi_pick[4] | lo_pick[4];
    idx = hi_pick[4] ? hi_pick[3:0] : lo_pick[3:0];
  end

endmodule : vic_prio_enc
`default_nettype wire
